// file: design/sub_exec_pkg.sv
// Constants and types for the subtract, return and set-carry execution block
package sub_exec_pkg;
    // ==========================================================
    // Widths
    localparam int NIB_W   = 4;
    localparam int ADDR_W  = 7;
    localparam int PTR_W   = 11;
    localparam int INSTR_W = 16;
    localparam int MEM_DEPTH = 128;

    // ==========================================================
    // Opcode fields
    localparam logic [8:0]  MEM_SUB_PREFIX   = 9'h028;   // 0001_0100_0 over bits 15..7
    localparam logic [8:0]  MEM_SUBST_PREFIX = 9'h02c;   // 0001_0110_0 over bits 15..7
    localparam logic [7:0]  IMM_SUB_PREFIX   = 8'h0e;    // 0000_1110 over bits 15..8
    localparam logic [7:0]  IMM_SUBST_PREFIX = 8'h0f;    // 0000_1111 over bits 15..8
    localparam logic [15:0] RETURN_CODE      = 16'h0200;
    localparam logic [15:0] SET_CARRY_CODE   = 16'h5020;
    localparam int IMM_LSB = 4;
    localparam int WR_LSB  = 0;

    // ==========================================================
    // Reset values
    localparam logic [10:0] PTR_RESET   = 11'h000;
    localparam logic [3:0]  ACC_RESET   = 4'h0;
    localparam logic        CARRY_RESET = 1'b0;
    localparam logic        ZERO_RESET  = 1'b0;
    localparam logic [10:0] PTR_STEP    = 11'h001;

    // ==========================================================
    // Controller states, one-hot
    typedef enum logic [1:0] {
        ST_DECODE = 2'b01,
        ST_EXEC   = 2'b10
    } exec_state_t;
endpackage

// file: design/nibble_mem_if.sv
// Interface between the execution controller and the data nibble memory
`timescale 1ns/10ps
interface nibble_mem_if;
    import sub_exec_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0]  wdata;
    logic              we;
    logic [NIB_W-1:0]  rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// file: design/nibble_mem.sv
// Data memory of nibbles with registered read data
`timescale 1ns/10ps
module nibble_mem
    import sub_exec_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    // Clock
    input  wire logic     clk_in,
    // Memory port
    nibble_mem_if.mem     port
);
    logic [NIB_W-1:0] cells [DEPTH];

    // Write on strobe, read data registered every edge
    always_ff @(posedge clk_in) begin
        if (port.we) begin
            cells[port.addr] <= port.wdata;
        end
        port.rdata <= cells[port.addr];
    end
endmodule

// file: design/subtract_return_setcarry_exec.sv
// Decode and execute of subtract-with-borrow, return and set-carry opcodes
`timescale 1ns/10ps
module subtract_return_setcarry_exec
    import sub_exec_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // Instruction stream
    input  wire logic               instr_valid_in,
    input  wire logic [INSTR_W-1:0] instr_in,
    output logic                    instr_ready_out,
    // Return stack
    input  wire logic [PTR_W-1:0]   stack_top_in,
    output logic                    stack_pop_out,
    // Memory preload
    input  wire logic               load_valid_in,
    input  wire logic [ADDR_W-1:0]  load_addr_in,
    input  wire logic [NIB_W-1:0]   load_data_in,
    // Core state
    output logic [PTR_W-1:0]        instr_pointer_out,
    output logic [NIB_W-1:0]        result_nibble_out,
    output logic                    carry_borrow_out,
    output logic                    zero_result_out,
    output logic                    unknown_op_out
);
    // ==========================================================
    // Timing of one machine cycle
    // Decode phase (ready high): an offered opcode is taken at the edge, and the
    // operand nibble that it names is read from memory at that same edge.
    // Exec phase (ready low): the registered operand is combined with the
    // accumulator or the immediate field, and at the closing edge the
    // accumulator, both flags, the pointer and, for store forms, the memory
    // nibble are all updated together.
    // A return raises the stack pop at that same closing edge, as a single-cycle pulse.
    // Hazards
    // The memory read is registered, so the operand must be addressed from the
    // incoming opcode, not the held one; the held opcode only steers write back.
    // Preload writes are honoured only while no opcode is offered, so a
    // preload can never collide with a write back.
    // Opcodes outside the six decoded here only step the pointer and raise
    // the unknown flag; all other state is left as it was.
    // ==========================================================
    // Helpers
    // Borrow subtract: bit 4 is the borrow out of bit 3
    function automatic logic [NIB_W:0] sub_borrow(input logic [NIB_W-1:0] a,
                                                 input logic [NIB_W-1:0] b,
                                                 input logic             c);
        sub_borrow = {1'b0, a} - {1'b0, b} - {{NIB_W{1'b0}}, c};
    endfunction

    // Operand address: working register forms reach the low sixteen nibbles
    function automatic logic [ADDR_W-1:0] operand_addr(input logic [INSTR_W-1:0] code);
        if (code[15:9] == IMM_SUB_PREFIX[7:1]) begin
            operand_addr = {3'h0, code[WR_LSB +: NIB_W]};
        end else begin
            operand_addr = code[ADDR_W-1:0];
        end
    endfunction

    // ==========================================================
    // Storage
    exec_state_t        state_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic [PTR_W-1:0]   instr_pointer_reg;
    logic [NIB_W-1:0]   result_nibble_reg;
    logic               carry_borrow_reg;
    logic               zero_result_reg;
    logic               pop_reg;
    logic               unknown_reg;
    nibble_mem_if       mem_bus ();

    // Data memory; read data is registered, one cycle behind the address
    nibble_mem #(
        .DEPTH (MEM_DEPTH)
    ) u_mem (
        .clk_in (clk_in),
        .port   (mem_bus.mem)
    );

    // ==========================================================
    // Decode of the held opcode
    // Memory forms carry a seven bit address in bits 6..0 with bit 7 clear;
    // the two differ only in bit 9, which selects write back.
    // Immediate forms carry the immediate in bits 7..4 and the working
    // register in bits 3..0; bit 8 selects write back.
    // Return and set carry are matched on the whole word, so no field of
    // theirs can alias a subtract.
    logic               is_mem_sub;
    logic               is_mem_subst;
    logic               is_imm_sub;
    logic               is_imm_subst;
    logic               is_return;
    logic               is_set_carry;
    logic               is_sub;
    logic [NIB_W-1:0]   subtrahend;
    logic [NIB_W:0]     diff;
    logic               start;

    assign is_mem_sub   = instr_reg[15:7] == MEM_SUB_PREFIX;
    assign is_mem_subst = instr_reg[15:7] == MEM_SUBST_PREFIX;
    assign is_imm_sub   = instr_reg[15:8] == IMM_SUB_PREFIX;
    assign is_imm_subst = instr_reg[15:8] == IMM_SUBST_PREFIX;
    assign is_return    = instr_reg == RETURN_CODE;
    assign is_set_carry = instr_reg == SET_CARRY_CODE;
    assign is_sub       = is_mem_sub | is_mem_subst | is_imm_sub | is_imm_subst;
    assign start        = (state_reg == ST_DECODE) && instr_valid_in;

    // Memory forms subtract the accumulator, immediate forms the nibble field
    assign subtrahend = (is_imm_sub | is_imm_subst) ?
                        instr_reg[IMM_LSB +: NIB_W] : result_nibble_reg;
    assign diff       = sub_borrow(mem_bus.rdata, subtrahend, carry_borrow_reg);

    // ==========================================================
    // Memory addressing: incoming opcode selects operand, held opcode writes back
    always_comb begin
        mem_bus.we    = 1'b0;
        mem_bus.wdata = diff[NIB_W-1:0];
        mem_bus.addr  = load_addr_in;
        if (state_reg == ST_EXEC) begin
            // Write back goes to the operand read in the decode phase
            mem_bus.addr = operand_addr(instr_reg);
            mem_bus.we   = is_mem_subst | is_imm_subst;
        end else if (instr_valid_in) begin
            // Address the operand of the incoming opcode
            mem_bus.addr = operand_addr(instr_in);
        end else begin
            // Idle decode phase: the preload port owns the memory
            mem_bus.we    = load_valid_in;
            mem_bus.wdata = load_data_in;
        end
    end

    // ==========================================================
    // Sequencer: decode phase fetches operand, exec phase retires
    // An unused state code falls back to decode, costing one slot at most
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_DECODE;
        end else begin
            case (state_reg)
                ST_DECODE: begin
                    if (instr_valid_in) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_reg <= ST_DECODE;
                end
                default: begin
                    state_reg <= ST_DECODE;
                end
            endcase
        end
    end

    // Opcode capture
    // Held for the exec phase; the port may change once the opcode is taken
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_reg <= 16'h0000;
        end else if (start) begin
            instr_reg <= instr_in;
        end
    end

    // Instruction pointer: reload on return, else step
    // Wraps at eleven bits; a return takes the stack entry as it stands
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_pointer_reg <= PTR_RESET;
        end else if (state_reg == ST_EXEC) begin
            if (is_return) begin
                instr_pointer_reg <= stack_top_in;
            end else begin
                instr_pointer_reg <= instr_pointer_reg + PTR_STEP;
            end
        end
    end

    // Accumulator and flags
    // Set carry touches the carry alone; accumulator and zero flag hold,
    // and memory too, since no write strobe is raised for it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_nibble_reg <= ACC_RESET;
            carry_borrow_reg  <= CARRY_RESET;
            zero_result_reg   <= ZERO_RESET;
        end else if (state_reg == ST_EXEC) begin
            if (is_sub) begin
                result_nibble_reg <= diff[NIB_W-1:0];
                carry_borrow_reg  <= diff[NIB_W];
                zero_result_reg   <= diff[NIB_W-1:0] == 4'h0;
            end else if (is_set_carry) begin
                carry_borrow_reg  <= 1'b1;
            end
        end
    end

    // Stack pop pulse and unknown opcode flag
    // The unknown flag is a level that each retiring opcode rewrites
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pop_reg     <= 1'b0;
            unknown_reg <= 1'b0;
        end else begin
            pop_reg <= (state_reg == ST_EXEC) && is_return;
            if (state_reg == ST_EXEC) begin
                unknown_reg <= !(is_sub | is_return | is_set_carry);
            end
        end
    end

    // ==========================================================
    // Outputs
    // All are flip-flop bits; ready is the decode bit of the one-hot state
    assign instr_ready_out   = state_reg[0];
    assign stack_pop_out     = pop_reg;
    assign instr_pointer_out = instr_pointer_reg;
    assign result_nibble_out = result_nibble_reg;
    assign carry_borrow_out  = carry_borrow_reg;
    assign zero_result_out   = zero_result_reg;
    assign unknown_op_out    = unknown_reg;
endmodule

// file: testbench/sub_exec_checker.sv
// Port checks for the subtract, return and set-carry block
`timescale 1ns/10ps
module sub_exec_checker
    import sub_exec_pkg::*;
(
    // Clock and reset
    input wire logic               clk_in,
    input wire logic               rst_in,
    // Instruction and stack
    input wire logic               instr_valid_in,
    input wire logic [INSTR_W-1:0] instr_in,
    input wire logic               instr_ready_out,
    input wire logic [PTR_W-1:0]   stack_top_in,
    input wire logic               stack_pop_out,
    // Core state
    input wire logic [PTR_W-1:0]   instr_pointer_out,
    input wire logic [NIB_W-1:0]   result_nibble_out,
    input wire logic               carry_borrow_out,
    input wire logic               zero_result_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ==========
    // Accepted opcode classes
    wire logic       take    = instr_ready_out && instr_valid_in;
    wire logic       is_imm  = take && instr_in[15:9] == 7'h07;
    wire logic       is_mem  = take && (instr_in[15:7] & 9'h1fb) == 9'h028;
    wire logic       is_ret  = take && instr_in == RETURN_CODE;
    wire logic       is_setc = take && instr_in == SET_CARRY_CODE;
    wire logic [3:0] imm_nib = instr_in[7:4];
    // Decode phase, one busy cycle, decode again
    sequence retire_s;
        ##1 !instr_ready_out ##1 instr_ready_out;
    endsequence
    ready_gap_a: assert property (take |-> retire_s)
        else $error("machine cycle not two clocks");
    ret_reload_a: assert property (is_ret |-> ##2 instr_pointer_out == $past(stack_top_in))
        else $error("pointer not reloaded from stack");
    ret_pop_a: assert property (is_ret |-> ##[2:3] stack_pop_out)
        else $error("no stack pop after return");
    ptr_step_a: assert property (take && !is_ret |-> ##2 instr_pointer_out ==
        $past(instr_pointer_out) + 11'h001) else $error("pointer did not step");
    setc_hold_a: assert property (is_setc |-> ##2 carry_borrow_out &&
        $stable(result_nibble_out) && $stable(zero_result_out)) else $error("set carry wrong");
    zero_flag_a: assert property (is_imm || is_mem |-> ##2
        zero_result_out == (result_nibble_out == 4'h0)) else $error("zero flag wrong");
    imm_borrow_a: assert property (is_imm |-> ##2 carry_borrow_out == (5'(result_nibble_out) +
        5'($past(imm_nib, 2)) + 5'($past(carry_borrow_out)) > 5'd15)) else $error("imm borrow");
    mem_borrow_a: assert property (is_mem |-> ##2 carry_borrow_out == (5'(result_nibble_out) +
        5'($past(result_nibble_out)) + 5'($past(carry_borrow_out)) > 5'd15)) else $error("borrow");
endmodule
bind subtract_return_setcarry_exec sub_exec_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
    .stack_top_in(stack_top_in), .stack_pop_out(stack_pop_out),
    .instr_pointer_out(instr_pointer_out), .result_nibble_out(result_nibble_out),
    .carry_borrow_out(carry_borrow_out), .zero_result_out(zero_result_out));

// file: testbench/testbench.sv
// Self-checking bench for the subtract, return and set-carry block
`timescale 1ns/10ps
module testbench;
    import sub_exec_pkg::*;
    // ==========
    // Bench signals
    logic        clk_in = 0;
    logic        rst_in = 1;
    logic        instr_valid_in = 0;
    logic        load_valid_in = 0;
    logic [15:0] instr_in = '0;
    logic [10:0] stack_top_in = '0;
    logic [6:0]  load_addr_in = '0;
    logic [3:0]  load_data_in = '0;
    logic [10:0] instr_pointer_out;
    logic [10:0] ptr_exp = '0;
    logic [3:0]  result_nibble_out;
    logic        instr_ready_out, stack_pop_out, carry_borrow_out;
    logic        zero_result_out, unknown_op_out;
    int          error_cnt = 0;
    int          compares = 0;
    // 50 MHz clock
    always #10 clk_in = ~clk_in;
    subtract_return_setcarry_exec i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
        .stack_top_in(stack_top_in), .stack_pop_out(stack_pop_out),
        .load_valid_in(load_valid_in), .load_addr_in(load_addr_in), .load_data_in(load_data_in),
        .instr_pointer_out(instr_pointer_out), .result_nibble_out(result_nibble_out),
        .carry_borrow_out(carry_borrow_out), .zero_result_out(zero_result_out),
        .unknown_op_out(unknown_op_out));
    // ==========
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Preload one memory nibble while idle
    task automatic load(input logic [6:0] a, input logic [3:0] d);
        @(posedge clk_in);
        load_valid_in <= 1'b1;
        load_addr_in  <= a;
        load_data_in  <= d;
        @(posedge clk_in);
        load_valid_in <= 1'b0;
    endtask
    // Issue one opcode, let it retire and judge the core state
    task automatic op(input logic [15:0] code, input logic [3:0] acc, input logic c, z);
        int n;
        for (n = 0; n < 8 && instr_ready_out !== 1'b1; n++) @(posedge clk_in);
        if (n == 8) begin
            error_cnt++;
            close_out();
        end
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        instr_in       <= code;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        @(posedge clk_in);
        #1;
        ptr_exp = (code == RETURN_CODE) ? stack_top_in : ptr_exp + 11'h001;
        chk("acc", 16'(result_nibble_out), 16'(acc));
        chk("carry", 16'(carry_borrow_out), 16'(c));
        chk("zero", 16'(zero_result_out), 16'(z));
        chk("pointer", 16'(instr_pointer_out), 16'(ptr_exp));
    endtask
    // ==========
    // Scenarios
    task automatic t_mem();
        op(16'h1405, 4'h3, 1'b0, 1'b0);
        op(16'h1406, 4'hf, 1'b1, 1'b0);
    endtask
    task automatic t_imm_setc();
        op(16'h0e61, 4'h0, 1'b0, 1'b1);
        op(SET_CARRY_CODE, 4'h0, 1'b1, 1'b1);
    endtask
    // Store forms, each read back through a plain subtract
    task automatic t_store();
        op(16'h1605, 4'h2, 1'b0, 1'b0);
        op(16'h1405, 4'h0, 1'b0, 1'b1);
        op(16'h0f21, 4'h5, 1'b0, 1'b0);
        op(16'h0e51, 4'h0, 1'b0, 1'b1);
    endtask
    // Return reloads the pointer and pops once
    task automatic t_ret();
        int pops;
        pops = 0;
        @(posedge clk_in);
        stack_top_in <= 11'h5a3;
        op(RETURN_CODE, 4'h0, 1'b0, 1'b1);
        repeat (3) begin
            pops += int'(stack_pop_out === 1'b1);
            @(posedge clk_in);
            #1;
        end
        chk("pops", 16'(pops), 16'h0001);
        op(16'hffff, 4'h0, 1'b0, 1'b1);
        chk("unknown", 16'(unknown_op_out), 16'h0001);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        load(7'h05, 4'h3);
        load(7'h06, 4'h2);
        load(7'h01, 4'h7);
        t_mem();
        t_imm_setc();
        t_store();
        t_ret();
        close_out();
    end
endmodule
